/* verilog/frame_sched_pkg.sv */
// Constants shared by the reader frame scheduler
package frame_sched_pkg;
  // Clock and derived timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int SYNC_DELAY_NOM_US = 800;
  localparam int SYNC_DELAY_TOL_US = 15;
  localparam int SYNC_DELAY_MIN_US = SYNC_DELAY_NOM_US - SYNC_DELAY_TOL_US;
  localparam int SYNC_DELAY_MAX_US = SYNC_DELAY_NOM_US + SYNC_DELAY_TOL_US;
  localparam int ACCESS_LOST_S = 10;
  localparam int ACCESS_LOST_CYCLES = ACCESS_LOST_S * CLK_HZ;
  localparam int FRAME_CYCLES_DEF = 50_000;
  localparam int BURST_OFF_ADVISED_MIN = 15;

  // Register word addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BURST = 8'h04;
  localparam logic [7:0] ADDR_SYNC_DELAY = 8'h08;
  localparam logic [7:0] ADDR_SYNC_PULSE = 8'h0c;
  localparam logic [7:0] ADDR_LANE = 8'h10;
  localparam logic [7:0] ADDR_TAG = 8'h14;
  localparam logic [7:0] ADDR_DIO = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_FRAME_COUNT = 8'h20;

  // Control field positions
  localparam int CTRL_BURST_EN = 0;
  localparam int CTRL_ROLE_LSB = 1;
  localparam int CTRL_LANE_BASED = 3;
  localparam int CTRL_INT_ACT_EN = 4;
  localparam int CTRL_EXT_ACT_EN = 5;
  localparam int CTRL_EH_ALT = 6;
  localparam int CTRL_NORMAL_CMD = 7;
  localparam int CTRL_ML_LSB = 8;
  localparam int CTRL_LANES_LSB = 10;
  localparam int CTRL_DISC_LSB = 12;
  localparam int CTRL_MUTE_CMD = 15;

  // Values after reset
  localparam logic [31:0] CTRL_RST = 32'h0000_0070;
  localparam logic [31:0] BURST_RST = 32'h0010_0010;
  localparam logic [9:0] SYNC_DELAY_RST = 10'h320;
  localparam logic [31:0] SYNC_PULSE_RST = 32'h0064_0000;
  localparam logic [31:0] LANE_RST = 32'h0204_0a01;
  localparam logic [31:0] TAG_RST = 32'h0004_0310;

  typedef enum logic [1:0] {ROLE_NONE = 2'h0, ROLE_MASTER = 2'h1, ROLE_SLAVE = 2'h2} sync_role_t;
  typedef enum logic [1:0] {ML_SINGLE = 2'h0, ML_MAIN_TX = 2'h1, ML_LANE_TXRX = 2'h2} ml_mode_t;
  typedef enum logic [1:0] {DISC_ENTRY = 2'h0, DISC_EXIT = 2'h1, DISC_ASAP = 2'h2} disc_mode_t;
  // Gray order along idle, present, accessed; sleep between accessed and idle
  typedef enum logic [1:0] {TAG_IDLE = 2'h0, TAG_PRESENT = 2'h1, TAG_ACCESSED = 2'h3, TAG_SLEEP = 2'h2} tag_state_t;
endpackage : frame_sched_pkg

/* verilog/reader_frame_scheduler.sv */
// Frame scheduler: burst gating, frame sync, antenna rotation, tag tracking, lane decision, digital I/O
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module reader_frame_scheduler #(
  parameter int FRAME_CYCLES = frame_sched_pkg::FRAME_CYCLES_DEF,
  parameter int ACCESS_LOST_CYCLES = frame_sched_pkg::ACCESS_LOST_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Power-up straps, caught after reset release
  input wire logic init_mute_strap,
  input wire logic [6:0] dout_power_up,
  // Sync pin
  input wire logic sync_in,
  output logic sync_out,
  // Radio control
  output logic tx_enable,
  output logic frame_start,
  output logic lane_based_frame,
  output logic ext_header_alternating,
  output logic [4:0] tx_ant_sel,
  output logic [4:0] rx_ant_sel,
  // Transponder events
  input wire logic act_msg,
  input wire logic act_external,
  input wire logic access_ok,
  input wire logic access_fail,
  input wire logic sleep_cmd,
  output logic tag_present,
  output logic tag_lost,
  output logic lane_valid,
  output logic [1:0] lane_id,
  // Digital I/O
  input wire logic [7:0] din,
  output logic [6:0] dout,
  output logic [7:0] din_sensed
);
  // Configuration registers
  logic [31:0] ctrl_reg, ctrl_next, burst_reg, burst_next, pulse_reg, pulse_next;
  logic [31:0] lane_cfg_reg, lane_cfg_next, tag_cfg_reg, tag_cfg_next;
  logic [9:0] delay_us_reg, delay_us_next;
  logic [15:0] sense_cfg_reg, sense_cfg_next;
  logic [6:0] dout_reg, dout_next;
  logic [31:0] rdata_reg, rdata_next;
  logic boot_reg, muted_reg, muted_next;
  // Frame, sync and burst state
  logic [31:0] fc_reg, fc_next, frame_cnt_reg, frame_cnt_next;
  logic [15:0] slave_cnt_reg, slave_cnt_next, burst_cnt_reg, burst_cnt_next;
  logic slave_arm_reg, slave_arm_next, sync_d_reg, off_phase_reg, off_phase_next;
  logic frame_tick, sync_out_next, tx_en_next;
  // Antenna state
  logic [1:0] lane_reg, lane_next;
  logic [7:0] lane_frames_reg, lane_frames_next;
  logic [4:0] tx_ant_reg, tx_ant_next, rx_ant_reg, rx_ant_next;
  // Tag state
  frame_sched_pkg::tag_state_t tag_reg, tag_next;
  logic [7:0] act_cnt_reg [4];
  logic [7:0] act_cnt_next [4];
  logic [31:0] tmo_reg, tmo_next;
  logic [15:0] win_reg, win_next;
  logic [7:0] retry_reg, retry_next;
  logic lost_reg, lost_next, lvalid_reg, lvalid_next;
  logic [1:0] lid_reg, lid_next;
  logic [2:0] pick;
  logic act_ok;
  logic [7:0] sense_reg, sense_next;

  // Lane choice from counts: bit 2 set when counts qualify
  function automatic logic [2:0] lane_pick(input logic [31:0] cnts, input logic [1:0] nl,
                                           input logic [7:0] min_act, input logic [7:0] delta);
    logic [1:0] best;
    logic [9:0] total;
    logic ok;
    best = 2'h0;
    total = 10'h000;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (2'(i) <= nl) begin
        total = total + {2'h0, cnts[i*8 +: 8]};
        if (cnts[i*8 +: 8] > cnts[best*8 +: 8]) begin
          best = 2'(i);
        end
      end
    end
    if (total < {2'h0, min_act}) begin
      ok = 1'b0;
    end
    for (int i = 0; i < 4; i++) begin
      if (2'(i) <= nl && 2'(i) != best &&
          {1'b0, cnts[best*8 +: 8]} < {1'b0, cnts[i*8 +: 8]} + {1'b0, delta}) begin
        ok = 1'b0;
      end
    end
    return {ok, best};
  endfunction : lane_pick

  // Register writes, reads and straps
  always_comb begin
    ctrl_next = ctrl_reg;
    burst_next = burst_reg;
    pulse_next = pulse_reg;
    lane_cfg_next = lane_cfg_reg;
    tag_cfg_next = tag_cfg_reg;
    delay_us_next = delay_us_reg;
    sense_cfg_next = sense_cfg_reg;
    dout_next = dout_reg;
    muted_next = muted_reg;
    rdata_next = 32'h0000_0000;
    if (boot_reg) begin
      muted_next = init_mute_strap;
      dout_next = dout_power_up;
    end
    if (reg_wr) begin
      case (reg_addr)
        frame_sched_pkg::ADDR_CTRL: begin
          ctrl_next = reg_wdata & 32'h0000_3f7f;
          if (reg_wdata[frame_sched_pkg::CTRL_NORMAL_CMD]) begin
            muted_next = 1'b0;
          end else if (reg_wdata[frame_sched_pkg::CTRL_MUTE_CMD]) begin
            muted_next = 1'b1;
          end
        end
        frame_sched_pkg::ADDR_BURST: burst_next = reg_wdata;
        frame_sched_pkg::ADDR_SYNC_DELAY: begin
          if (reg_wdata[9:0] < 10'(frame_sched_pkg::SYNC_DELAY_MIN_US)) begin
            delay_us_next = 10'(frame_sched_pkg::SYNC_DELAY_MIN_US);
          end else if (reg_wdata[9:0] > 10'(frame_sched_pkg::SYNC_DELAY_MAX_US) || reg_wdata[31:10] != 22'h0) begin
            delay_us_next = 10'(frame_sched_pkg::SYNC_DELAY_MAX_US);
          end else begin
            delay_us_next = reg_wdata[9:0];
          end
        end
        frame_sched_pkg::ADDR_SYNC_PULSE: pulse_next = reg_wdata;
        frame_sched_pkg::ADDR_LANE: lane_cfg_next = reg_wdata;
        frame_sched_pkg::ADDR_TAG: tag_cfg_next = reg_wdata;
        frame_sched_pkg::ADDR_DIO: begin
          dout_next = reg_wdata[6:0];
          sense_cfg_next = reg_wdata[23:8];
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        frame_sched_pkg::ADDR_CTRL: rdata_next = ctrl_reg;
        frame_sched_pkg::ADDR_BURST: rdata_next = burst_reg;
        frame_sched_pkg::ADDR_SYNC_DELAY: rdata_next = {22'h0, delay_us_reg};
        frame_sched_pkg::ADDR_SYNC_PULSE: rdata_next = pulse_reg;
        frame_sched_pkg::ADDR_LANE: rdata_next = lane_cfg_reg;
        frame_sched_pkg::ADDR_TAG: rdata_next = tag_cfg_reg;
        frame_sched_pkg::ADDR_DIO: rdata_next = {8'h0, sense_cfg_reg, 1'b0, dout_reg};
        frame_sched_pkg::ADDR_STATUS: rdata_next = {sense_reg, 7'h00, retry_reg, lid_reg, lvalid_reg,
                                                    tag_reg, lane_reg, off_phase_reg, muted_reg};
        frame_sched_pkg::ADDR_FRAME_COUNT: rdata_next = frame_cnt_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctrl_reg <= frame_sched_pkg::CTRL_RST;
      burst_reg <= frame_sched_pkg::BURST_RST;
      pulse_reg <= frame_sched_pkg::SYNC_PULSE_RST;
      lane_cfg_reg <= frame_sched_pkg::LANE_RST;
      tag_cfg_reg <= frame_sched_pkg::TAG_RST;
      delay_us_reg <= frame_sched_pkg::SYNC_DELAY_RST;
      sense_cfg_reg <= 16'h0000;
      dout_reg <= 7'h00;
      muted_reg <= 1'b1;
      boot_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      burst_reg <= burst_next;
      pulse_reg <= pulse_next;
      lane_cfg_reg <= lane_cfg_next;
      tag_cfg_reg <= tag_cfg_next;
      delay_us_reg <= delay_us_next;
      sense_cfg_reg <= sense_cfg_next;
      dout_reg <= dout_next;
      muted_reg <= muted_next;
      boot_reg <= 1'b0;
      rdata_reg <= rdata_next;
    end
  end

  // Frame counter, slave sync, burst cycle and master sync pulse
  always_comb begin
    slave_arm_next = slave_arm_reg;
    slave_cnt_next = slave_cnt_reg;
    frame_tick = (fc_reg == 32'(FRAME_CYCLES - 1));
    if (ctrl_reg[2:1] == frame_sched_pkg::ROLE_SLAVE) begin
      if (sync_d_reg && !sync_in) begin
        slave_arm_next = 1'b1;
        slave_cnt_next = 16'(delay_us_reg) * 16'(frame_sched_pkg::CYC_PER_US) - 16'h0001;
      end else if (slave_arm_reg) begin
        if (slave_cnt_reg == 16'h0000) begin
          slave_arm_next = 1'b0;
          frame_tick = 1'b1;
        end else begin
          slave_cnt_next = slave_cnt_reg - 16'h0001;
        end
      end
    end else begin
      slave_arm_next = 1'b0;
    end
    fc_next = frame_tick ? 32'h0 : fc_reg + 32'h1;
    frame_cnt_next = frame_tick ? frame_cnt_reg + 32'h1 : frame_cnt_reg;
    off_phase_next = off_phase_reg;
    burst_cnt_next = burst_cnt_reg;
    if (!ctrl_reg[frame_sched_pkg::CTRL_BURST_EN]) begin
      off_phase_next = 1'b0;
      burst_cnt_next = 16'h0000;
    end else if (frame_tick) begin
      if (burst_cnt_reg + 16'h0001 >= (off_phase_reg ? burst_reg[31:16] : burst_reg[15:0])) begin
        off_phase_next = !off_phase_reg;
        burst_cnt_next = 16'h0000;
      end else begin
        burst_cnt_next = burst_cnt_reg + 16'h0001;
      end
    end
    tx_en_next = !muted_next && !off_phase_next;
    sync_out_next = (ctrl_reg[2:1] == frame_sched_pkg::ROLE_MASTER) &&
                    (fc_next >= {16'h0, pulse_reg[15:0]}) &&
                    (fc_next < {16'h0, pulse_reg[15:0]} + {16'h0, pulse_reg[31:16]}) &&
                    !(ctrl_reg[frame_sched_pkg::CTRL_BURST_EN] && !off_phase_next);
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      fc_reg <= 32'h0;
      frame_cnt_reg <= 32'h0;
      slave_arm_reg <= 1'b0;
      slave_cnt_reg <= 16'h0000;
      sync_d_reg <= 1'b0;
      off_phase_reg <= 1'b0;
      burst_cnt_reg <= 16'h0000;
      tx_enable <= 1'b0;
      sync_out <= 1'b0;
      frame_start <= 1'b0;
    end else begin
      fc_reg <= fc_next;
      frame_cnt_reg <= frame_cnt_next;
      slave_arm_reg <= slave_arm_next;
      slave_cnt_reg <= slave_cnt_next;
      sync_d_reg <= sync_in;
      off_phase_reg <= off_phase_next;
      burst_cnt_reg <= burst_cnt_next;
      tx_enable <= tx_en_next;
      sync_out <= sync_out_next;
      frame_start <= frame_tick;
    end
  end

  // Antenna rotation over the active lanes
  always_comb begin
    lane_next = lane_reg;
    lane_frames_next = lane_frames_reg;
    if (frame_tick) begin
      if (lane_frames_reg + 8'h01 >= lane_cfg_reg[7:0]) begin
        lane_frames_next = 8'h00;
        lane_next = (lane_reg >= ctrl_reg[11:10]) ? 2'h0 : lane_reg + 2'h1;
      end else begin
        lane_frames_next = lane_frames_reg + 8'h01;
      end
    end
    case (ctrl_reg[9:8])
      frame_sched_pkg::ML_MAIN_TX: begin
        tx_ant_next = 5'h01;
        rx_ant_next = 5'(5'h02 << lane_next);
      end
      frame_sched_pkg::ML_LANE_TXRX: begin
        tx_ant_next = 5'(5'h02 << lane_next);
        rx_ant_next = 5'(5'h02 << lane_next);
      end
      default: begin
        tx_ant_next = 5'h01;
        rx_ant_next = 5'h01;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      lane_reg <= 2'h0;
      lane_frames_reg <= 8'h00;
      tx_ant_reg <= 5'h01;
      rx_ant_reg <= 5'h01;
    end else begin
      lane_reg <= lane_next;
      lane_frames_reg <= lane_frames_next;
      tx_ant_reg <= tx_ant_next;
      rx_ant_reg <= rx_ant_next;
    end
  end

  // Transponder tracking and lane decision
  assign act_ok = act_msg && (act_external ? ctrl_reg[frame_sched_pkg::CTRL_EXT_ACT_EN]
                                           : ctrl_reg[frame_sched_pkg::CTRL_INT_ACT_EN]);
  assign pick = lane_pick({act_cnt_reg[3], act_cnt_reg[2], act_cnt_reg[1], act_cnt_reg[0]},
                          ctrl_reg[11:10], lane_cfg_reg[23:16], lane_cfg_reg[31:24]);

  always_comb begin
    tag_next = tag_reg;
    tmo_next = tmo_reg;
    win_next = win_reg;
    retry_next = retry_reg;
    lost_next = 1'b0;
    lvalid_next = lvalid_reg;
    lid_next = lid_reg;
    for (int i = 0; i < 4; i++) begin
      act_cnt_next[i] = act_cnt_reg[i];
    end
    if (tag_reg != frame_sched_pkg::TAG_SLEEP && tag_reg != frame_sched_pkg::TAG_IDLE && frame_tick) begin
      win_next = (win_reg == 16'hffff) ? win_reg : win_reg + 16'h0001;
    end
    case (tag_reg)
      frame_sched_pkg::TAG_IDLE: begin
        if (act_ok) begin
          tag_next = frame_sched_pkg::TAG_PRESENT;
          tmo_next = 32'h0;
          win_next = 16'h0000;
          retry_next = 8'h00;
          lvalid_next = 1'b0;
          for (int i = 0; i < 4; i++) begin
            act_cnt_next[i] = (2'(i) == lane_reg) ? 8'h01 : 8'h00;
          end
        end
      end
      frame_sched_pkg::TAG_PRESENT, frame_sched_pkg::TAG_ACCESSED: begin
        if (act_ok && act_cnt_reg[lane_reg] != 8'hff) begin
          act_cnt_next[lane_reg] = act_cnt_reg[lane_reg] + 8'h01;
        end
        if (tag_reg == frame_sched_pkg::TAG_PRESENT) begin
          if (act_ok) begin
            tmo_next = 32'h0;
          end else if (frame_tick) begin
            tmo_next = tmo_reg + 32'h1;
          end
          if (tmo_next >= {24'h0, tag_cfg_reg[7:0]}) begin
            lost_next = 1'b1;
          end
        end else begin
          tmo_next = tmo_reg + 32'h1;
          if (tmo_reg >= 32'(ACCESS_LOST_CYCLES - 1)) begin
            lost_next = 1'b1;
          end
        end
        if (access_ok) begin
          tag_next = frame_sched_pkg::TAG_ACCESSED;
          tmo_next = 32'h0;
          retry_next = 8'h00;
        end else if (access_fail) begin
          if (retry_reg >= tag_cfg_reg[15:8]) begin
            lost_next = 1'b1;
          end else begin
            retry_next = retry_reg + 8'h01;
          end
        end
        if (!lvalid_reg && pick[2] && !lost_next) begin
          if ((ctrl_reg[13:12] == frame_sched_pkg::DISC_ENTRY && win_reg < {8'h00, lane_cfg_reg[15:8]}) ||
              ctrl_reg[13:12] == frame_sched_pkg::DISC_ASAP) begin
            lvalid_next = 1'b1;
            lid_next = pick[1:0];
          end
        end
        if (lost_next) begin
          tag_next = frame_sched_pkg::TAG_IDLE;
          if (!lvalid_reg && pick[2] && ctrl_reg[13:12] != frame_sched_pkg::DISC_ENTRY) begin
            lvalid_next = 1'b1;
            lid_next = pick[1:0];
          end
        end
        if (sleep_cmd && !lost_next) begin
          tag_next = frame_sched_pkg::TAG_SLEEP;
          tmo_next = 32'h0;
        end
      end
      frame_sched_pkg::TAG_SLEEP: begin
        if (frame_tick) begin
          tmo_next = tmo_reg + 32'h1;
        end
        if (tmo_next >= {16'h0, tag_cfg_reg[31:16]}) begin
          tag_next = frame_sched_pkg::TAG_IDLE;
        end
      end
      default: tag_next = frame_sched_pkg::TAG_IDLE;
    endcase
    sense_next = ~(din ^ sense_cfg_reg[15:8]) & sense_cfg_reg[7:0];
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tag_reg <= frame_sched_pkg::TAG_IDLE;
      tmo_reg <= 32'h0;
      win_reg <= 16'h0000;
      retry_reg <= 8'h00;
      lost_reg <= 1'b0;
      lvalid_reg <= 1'b0;
      lid_reg <= 2'h0;
      sense_reg <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        act_cnt_reg[i] <= 8'h00;
      end
    end else begin
      tag_reg <= tag_next;
      tmo_reg <= tmo_next;
      win_reg <= win_next;
      retry_reg <= retry_next;
      lost_reg <= lost_next;
      lvalid_reg <= lvalid_next;
      lid_reg <= lid_next;
      sense_reg <= sense_next;
      for (int i = 0; i < 4; i++) begin
        act_cnt_reg[i] <= act_cnt_next[i];
      end
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_reg;
  assign tx_ant_sel = tx_ant_reg;
  assign rx_ant_sel = rx_ant_reg;
  assign lane_based_frame = ctrl_reg[frame_sched_pkg::CTRL_LANE_BASED];
  assign ext_header_alternating = ctrl_reg[frame_sched_pkg::CTRL_EH_ALT];
  assign tag_present = tag_reg[0]; // Present and accessed are the only codes with bit 0 set
  assign tag_lost = lost_reg;
  assign lane_valid = lvalid_reg;
  assign lane_id = lid_reg;
  assign dout = dout_reg;
  assign din_sensed = sense_reg;
endmodule : reader_frame_scheduler

/* dv/frame_sched_properties.sv */
// Checker for port behaviour of the reader frame scheduler
`timescale 1ns/1ps
module frame_sched_checker #(
  parameter int FRAME_CYCLES = 100
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Straps and outputs
  input wire logic init_mute_strap,
  input wire logic [6:0] dout_power_up,
  input wire logic sync_out,
  input wire logic tx_enable,
  input wire logic frame_start,
  input wire logic [4:0] tx_ant_sel,
  input wire logic [4:0] rx_ant_sel,
  input wire logic tag_lost,
  input wire logic [6:0] dout
);
  logic burst_reg, burst_next, seen_reg, seen_next;
  logic [1:0] role_reg, role_next;
  logic [31:0] gap_reg, gap_next;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Shadow of burst enable and role, and cycles since the last frame start
  always_comb begin
    burst_next = burst_reg;
    role_next = role_reg;
    if (reg_wr && reg_addr == frame_sched_pkg::ADDR_CTRL) begin
      burst_next = reg_wdata[0];
      role_next = reg_wdata[2:1];
    end
    seen_next = seen_reg | frame_start;
    gap_next = frame_start ? 32'h1 : gap_reg + 32'h1;
  end
  // Register the shadow state
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      burst_reg <= 1'b0;
      role_reg <= 2'h0;
      seen_reg <= 1'b0;
      gap_reg <= 32'h0;
    end else begin
      burst_reg <= burst_next;
      role_reg <= role_next;
      seen_reg <= seen_next;
      gap_reg <= gap_next;
    end
  end
  sequence s_release;
    $rose(resetn);
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside read slot");
  a_frame_pulse: assert property (frame_start |=> !frame_start) else $error("frame start too long");
  a_frame_period: assert property (frame_start && seen_reg && role_reg != 2'h2 |-> gap_reg == FRAME_CYCLES)
    else $error("frame period wrong");
  a_lost_pulse: assert property (tag_lost |=> !tag_lost) else $error("lost pulse too long");
  a_ant_onehot: assert property ($onehot(tx_ant_sel) && $onehot(rx_ant_sel)) else $error("antenna not one-hot");
  a_sync_off_only: assert property (sync_out && burst_reg |-> !tx_enable) else $error("sync in on frame");
  a_dout_powerup: assert property (s_release |=> dout == $past(dout_power_up)) else $error("power-up outputs");
  a_strap_mute: assert property (s_release ##0 init_mute_strap |-> ##2 !tx_enable) else $error("not muted");
endmodule : frame_sched_checker
bind reader_frame_scheduler frame_sched_checker #(.FRAME_CYCLES(FRAME_CYCLES)) i_chk (.clk_sys, .resetn, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .init_mute_strap, .dout_power_up, .sync_out, .tx_enable, .frame_start,
  .tx_ant_sel, .rx_ant_sel, .tag_lost, .dout);

/* dv/zone_model.sv */
// Transponder in the reading zone and a neighbouring reader that sends sync pulses
`timescale 1ns/1ps
module zone_model (
  // Clock
  input wire logic clk_sys,
  // Reader side
  input wire logic frame_start,
  input wire logic tx_enable,
  // Bench control
  input wire logic in_zone,
  input wire logic nb_sync,
  // Messages and sync towards the reader
  output logic act_msg = 1'b0,
  output logic act_external = 1'b0,
  output logic sync_in = 1'b0
);
  // One internal activation message per transmitted frame while in the zone
  always_ff @(posedge clk_sys) begin
    act_msg <= in_zone && frame_start && tx_enable;
    act_external <= 1'b0;
    sync_in <= nb_sync; // Neighbour pulse, one cycle behind the request
  end
endmodule : zone_model

/* dv/reader_frame_scheduler_test.sv */
// Self-checking bench for the reader frame scheduler
`timescale 1ns/1ps
module reader_frame_scheduler_test;
  localparam int FC = 100;
  logic clk_sys = 0, resetn = 0, reg_wr = 0, reg_rd = 0, init_mute_strap = 1, access_ok = 0, access_fail = 0;
  logic sleep_cmd = 0, in_zone = 0, sync_in, sync_out, tx_enable, frame_start, lane_based_frame;
  logic ext_header_alternating, act_msg, act_external, tag_present, tag_lost, lane_valid, nb_sync = 0;
  logic [1:0] lane_id;
  logic [7:0] reg_addr = 8'h00, din = 8'h00, din_sensed;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [4:0] tx_ant_sel, rx_ant_sel, prev;
  logic [6:0] dout, dout_power_up = 7'h2d;
  int err_total = 0, total_checks = 0, n, m;
  always #10 clk_sys = ~clk_sys;
  reader_frame_scheduler #(.FRAME_CYCLES(FC), .ACCESS_LOST_CYCLES(200)) i_dut (.clk_sys, .resetn, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .init_mute_strap, .dout_power_up, .sync_in, .sync_out, .tx_enable,
    .frame_start, .lane_based_frame, .ext_header_alternating, .tx_ant_sel, .rx_ant_sel, .act_msg, .act_external,
    .access_ok, .access_fail, .sleep_cmd, .tag_present, .tag_lost, .lane_valid, .lane_id, .din, .dout, .din_sensed);
  zone_model i_zone (.clk_sys, .frame_start, .tx_enable, .in_zone, .nb_sync, .act_msg, .act_external, .sync_in);
  task results;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(nm, exp, reg_rdata);
  endtask : rd
  // Step to the next frame start or the tag loss, with a bound
  task step(input bit lost, input int lim, output int k);
    k = 0;
    do begin @(posedge clk_sys); #1; k++; end while ((lost ? tag_lost : frame_start) !== 1'b1 && k < lim);
    if ((lost ? tag_lost : frame_start) !== 1'b1) begin chk("wait bound", 1, 0); results(); end
  endtask : step
  task fs;
    step(0, 3 * FC, m);
  endtask : fs
  task t_reset;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    rd("ctrl", frame_sched_pkg::ADDR_CTRL, frame_sched_pkg::CTRL_RST);
    rd("lane", frame_sched_pkg::ADDR_LANE, frame_sched_pkg::LANE_RST);
    rd("unmapped", 8'h3c, 32'h0);
    chk("tx ant", 5'h01, tx_ant_sel);
    chk("rx ant", 5'h01, rx_ant_sel);
    chk("header", 1, ext_header_alternating);
    chk("frame type", 0, lane_based_frame);
    chk("dout", 7'h2d, dout);
    repeat (3) begin fs(); chk("muted", 0, tx_enable); end
    wr(frame_sched_pkg::ADDR_CTRL, 32'hf0);
    fs(); chk("normal", 1, tx_enable);
  endtask : t_reset
  task t_burst;
    wr(frame_sched_pkg::ADDR_SYNC_PULSE, 32'h0005_000a);
    wr(frame_sched_pkg::ADDR_BURST, 32'h0010_0002);
    wr(frame_sched_pkg::ADDR_CTRL, 32'h73);
    repeat (18 * FC) @(posedge clk_sys);
    n = 0; m = 0;
    repeat (18 * FC) begin @(posedge clk_sys); #1; n += tx_enable; m += sync_out; end
    chk("on cycles", 2 * FC, n);
    chk("sync cycles", 80, m);
    wr(frame_sched_pkg::ADDR_CTRL, 32'h70);
    m = 0;
    repeat (2 * FC) begin @(posedge clk_sys); #1; m += sync_out; end
    chk("no sync", 0, m);
  endtask : t_burst
  // Slave role: delay clamped to its floor, new frame that long after the neighbour's sync falls
  task t_slave;
    wr(frame_sched_pkg::ADDR_SYNC_DELAY, 32'h2bc);
    rd("delay clamp", frame_sched_pkg::ADDR_SYNC_DELAY, frame_sched_pkg::SYNC_DELAY_MIN_US);
    wr(frame_sched_pkg::ADDR_CTRL, 32'h74);
    fs();
    @(posedge clk_sys);
    nb_sync <= 1'b1;
    @(posedge clk_sys);
    nb_sync <= 1'b0;
    repeat (frame_sched_pkg::SYNC_DELAY_MIN_US * frame_sched_pkg::CYC_PER_US + 1) @(posedge clk_sys);
    #1 chk("slave early", 0, frame_start);
    @(posedge clk_sys);
    #1 chk("slave frame", 1, frame_start);
    wr(frame_sched_pkg::ADDR_CTRL, 32'h70);
  endtask : t_slave
  task t_lanes;
    for (int md = 1; md <= 2; md++) begin
      wr(frame_sched_pkg::ADDR_CTRL, 32'h470 | (md << 8));
      fs(); fs(); repeat (FC / 2) @(posedge clk_sys);
      #1 prev = rx_ant_sel;
      repeat (3) begin
        fs(); repeat (FC / 2) @(posedge clk_sys);
        #1 chk("rx lane", prev == 5'h02 ? 5'h04 : 5'h02, rx_ant_sel);
        chk("tx ant", md == 1 ? 5'h01 : rx_ant_sel, tx_ant_sel);
        prev = rx_ant_sel;
      end
    end
    wr(frame_sched_pkg::ADDR_CTRL, 32'h70);
  endtask : t_lanes
  task t_tags;
    @(posedge clk_sys); in_zone <= 1'b1;
    fs(); fs(); chk("no lane yet", 0, lane_valid);
    repeat (3) fs();
    @(posedge clk_sys); in_zone <= 1'b0;
    #1 chk("present", 1, tag_present);
    chk("lane", 3'h4, {lane_valid, lane_id});
    step(1, 25 * FC, n);
    chk("lost frames", 1, n >= 15 * FC && n <= 17 * FC);
    @(posedge clk_sys); in_zone <= 1'b1;
    fs(); @(posedge clk_sys); in_zone <= 1'b0;
    @(posedge clk_sys); access_ok <= 1'b1;
    @(posedge clk_sys); access_ok <= 1'b0;
    step(1, 400, n);
    chk("access lost time", 1, n >= 197 && n <= 203);
    @(posedge clk_sys); in_zone <= 1'b1;
    fs(); @(posedge clk_sys); in_zone <= 1'b0;
    repeat (3) begin @(posedge clk_sys); access_fail <= 1'b1; @(posedge clk_sys); access_fail <= 1'b0; end
    repeat (2) @(posedge clk_sys);
    #1 chk("kept after retries", 1, tag_present);
    @(posedge clk_sys); access_fail <= 1'b1;
    @(posedge clk_sys); access_fail <= 1'b0;
    #1 chk("lost after retries", 1, tag_lost);
    @(posedge clk_sys); in_zone <= 1'b1;
    fs(); repeat (2) @(posedge clk_sys);
    sleep_cmd <= 1'b1;
    @(posedge clk_sys); sleep_cmd <= 1'b0;
    fs(); fs(); chk("asleep", 0, tag_present);
    repeat (4) fs();
    chk("awake", 1, tag_present);
  endtask : t_tags
  task t_dio;
    wr(frame_sched_pkg::ADDR_DIO, 32'h0001_0311);
    din <= 8'hf1;
    repeat (3) @(posedge clk_sys);
    #1 chk("sensed", 8'h03, din_sensed);
    chk("dout", 7'h11, dout);
    @(posedge clk_sys); din <= 8'hfe;
    repeat (3) @(posedge clk_sys);
    #1 chk("sensed", 8'h00, din_sensed);
  endtask : t_dio
  initial begin
    t_reset();
    t_burst();
    t_slave();
    t_lanes();
    t_tags();
    t_dio();
    results();
  end
endmodule : reader_frame_scheduler_test
